/* File: acq_host_bus_port.sv */
// host bus port of the acquisition converter: pins, fifo, dma, irq, apb
//
// Summary of operation
// - bw high: upper byte floats, low byte used
// - bw low: all sixteen data lines used
// - drive data only while read and select low
// - accept data only while write and select low
// - select low halts internal clocking and conversion
// - address latch strobe falling edge captures address
// - five address lines decode registers, fifo, ram
// - sync input edge holds, next clock starts
// - sync output high from start to completion
// - reset makes the sync pin an input
// - interrupt pin low on unmasked interrupt source
// - reading interrupt status clears all, releases pin
// - dma request when fifo count equals threshold
// - word mode ignores lowest address line
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "acq_cfg.svh"
module acq_host_bus_port #(
    parameter int FIFO_DEPTH = 32,
    parameter int FIFO_AW = 5,
    parameter int IRAM_DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // host pins (asynchronous)
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale,
    input wire logic bus_width_select,
    input wire logic [4:0] address_lines,
    input wire logic [15:0] data_lines_in,
    output logic [15:0] data_lines_out,
    output logic [15:0] data_lines_oe,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe,
    output logic int_n,
    output logic dma_request_out,
    // converter core side (same clock)
    input wire logic [7:0] core_events,
    input wire logic result_valid,
    input wire logic [15:0] result_data,
    input wire logic conv_start,
    input wire logic conv_done,
    output logic core_clk_en,
    output logic sh_hold,
    output logic conv_trigger
);
    import acq_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    acq_pins_t pins_raw; // pins gathered as one bundle
    acq_pins_t p; // synchronised pins
    assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, ale: ale,
        bw: bus_width_select, sync_in: sync_in, addr: address_lines,
        data: data_lines_in};

    acq_sync2 #(.W($bits(acq_pins_t))) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pins_raw),
        .q(p)
    );

    // ------------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------------
    logic [4:0] lat_addr; // address held while the strobe is low
    logic lat_cs_n; // select held while the strobe is low

    // while the strobe is high the latch is transparent, so its last
    // value before the falling edge is what stays captured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_addr <= 5'h0_0;
            lat_cs_n <= 1'b1;
        end else if (p.ale) begin
            lat_addr <= p.addr;
            lat_cs_n <= p.cs_n;
        end
    end

    // strobe held high by a non-multiplexed host passes pins straight
    wire [4:0] eff_addr = p.ale ? p.addr : lat_addr;
    wire eff_cs_n = p.ale ? p.cs_n : lat_cs_n;
    wire rd_act = ~eff_cs_n & ~p.rd_n;
    wire wr_act = ~eff_cs_n & ~p.wr_n;
    wire byte_mode = p.bw;

    // ------------------------------------------------------------------
    // host address decode
    // ------------------------------------------------------------------
    // word mode drops the lowest line; byte mode uses it as lane select
    wire [3:0] word_idx = eff_addr[4:1];
    wire hi_byte = byte_mode & eff_addr[0];
    wire sel_iram = (word_idx[3] == `ACQ_W_IRAM_TOP);
    wire sel_cfg = (word_idx == `ACQ_W_CONFIG);
    wire sel_ie = (word_idx == `ACQ_W_INT_EN);
    wire sel_is = (word_idx == `ACQ_W_INT_STAT);
    wire sel_fifo = (word_idx == `ACQ_W_FIFO);

    // ------------------------------------------------------------------
    // host registers and state
    // ------------------------------------------------------------------
    acq_state_t state; // current host access phase
    acq_state_t next_state; // phase for the next cycle
    logic [15:0] config_reg; // device configuration word
    logic [15:0] int_en; // interrupt mask and dma threshold
    logic [7:0] int_stat; // pending host interrupt sources
    logic [15:0] rd_word; // word presented during a read
    logic [15:0] wr_word; // data captured during a write
    logic [15:0] iram_rdata; // instruction ram read data
    logic [15:0] fifo_rdata; // fifo head word
    logic [FIFO_AW:0] fifo_count; // results held
    logic [FIFO_AW-1:0] fifo_wptr; // next slot to fill
    logic [FIFO_AW-1:0] fifo_rptr; // oldest result
    logic sync_prev; // last sampled sync input level
    logic flush; // one-cycle fifo flush from software

    wire sync_dir = config_reg[`ACQ_CFG_SYNC_DIR];
    wire [FIFO_AW:0] dma_thr =
        int_en[`ACQ_IE_THR_HI:`ACQ_IE_THR_LO];

    // ------------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------------
    logic [15:0] read_mux; // word chosen by the decoded address
    always_comb begin
        read_mux = `ACQ_ZERO16;
        if (sel_iram) begin
            read_mux = iram_rdata;
        end else if (sel_cfg) begin
            read_mux = config_reg;
        end else if (sel_ie) begin
            read_mux = int_en;
        end else if (sel_is) begin
            read_mux = {8'h0_0, int_stat};
        end else if (sel_fifo) begin
            read_mux = fifo_rdata;
        end
    end

    // ------------------------------------------------------------------
    // access sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ACQ_IDLE: begin
                if (rd_act) begin
                    next_state = ACQ_READ;
                end else if (wr_act) begin
                    next_state = ACQ_WRITE;
                end
            end
            ACQ_READ: begin
                if (!rd_act) next_state = ACQ_IDLE;
            end
            ACQ_WRITE: begin
                if (!wr_act) next_state = ACQ_IDLE;
            end
            default: next_state = ACQ_IDLE;
        endcase
    end

    wire rd_start = (state == ACQ_IDLE) & rd_act;
    wire rd_end = (state == ACQ_READ) & ~rd_act;
    wire wr_end = (state == ACQ_WRITE) & ~wr_act;
    // in byte mode the fifo advances only after its upper byte is read
    wire pop = rd_end & sel_fifo & (~byte_mode | eff_addr[0]) &
        (fifo_count != '0);
    wire push = result_valid & (fifo_count != FIFO_DEPTH[FIFO_AW:0]);
    wire overflow = result_valid & ~push;
    wire clr_is = rd_start & sel_is;

    // byte writes merge into the stored word, keeping the other lane
    logic [15:0] old_word; // current value of the written word
    always_comb begin
        old_word = iram_rdata;
        if (sel_cfg) old_word = config_reg;
        if (sel_ie) old_word = int_en;
    end
    wire [15:0] merged = !byte_mode ? wr_word :
        (hi_byte ? {wr_word[7:0], old_word[7:0]}
                 : {old_word[15:8], wr_word[7:0]});

    // ------------------------------------------------------------------
    // host side register updates
    // ------------------------------------------------------------------
    // status is snapshot on the first read cycle so the clear is not seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ACQ_IDLE;
            rd_word <= `ACQ_ZERO16;
            wr_word <= `ACQ_ZERO16;
            config_reg <= `ACQ_CONFIG_RST;
            int_en <= `ACQ_INT_EN_RST;
        end else begin
            state <= next_state;
            if (rd_start || (state == ACQ_READ && !sel_is)) begin
                rd_word <= read_mux;
            end
            if (wr_act) wr_word <= p.data;
            if (wr_end && sel_cfg) config_reg <= merged;
            if (wr_end && sel_ie) int_en <= merged;
        end
    end

    // ------------------------------------------------------------------
    // host interrupt status
    // ------------------------------------------------------------------
    // a source arriving in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= 8'h0_0;
        end else begin
            int_stat <= (clr_is ? 8'h0_0 : int_stat) | core_events;
        end
    end

    // ------------------------------------------------------------------
    // memories
    // ------------------------------------------------------------------
    acq_mem #(.W(16), .DEPTH(IRAM_DEPTH), .AW(3)) u_iram (
        .pclk(pclk),
        .we(wr_end & sel_iram),
        .waddr(word_idx[2:0]),
        .wdata(merged),
        .raddr(word_idx[2:0]),
        .rdata(iram_rdata)
    );

    acq_mem #(.W(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .pclk(pclk),
        .we(push),
        .waddr(fifo_wptr),
        .wdata(result_data),
        .raddr(fifo_rptr),
        .rdata(fifo_rdata)
    );

    // ------------------------------------------------------------------
    // fifo pointers
    // ------------------------------------------------------------------
    // a full fifo drops new results and reports it as an overflow event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_wptr <= '0;
            fifo_rptr <= '0;
            fifo_count <= '0;
        end else if (flush) begin
            fifo_wptr <= '0;
            fifo_rptr <= '0;
            fifo_count <= '0;
        end else begin
            if (push) fifo_wptr <= fifo_wptr + 1'b1;
            if (pop) fifo_rptr <= fifo_rptr + 1'b1;
            if (push && !pop) begin
                fifo_count <= fifo_count + 1'b1;
            end else if (pop && !push) begin
                fifo_count <= fifo_count - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------------
    // all pin outputs are registered, so the data enables trail the synchronised
    // strobes by one cycle and read data by two; from a pin that is three and four cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_lines_out <= `ACQ_ZERO16;
            data_lines_oe <= `ACQ_ZERO16;
            int_n <= 1'b1;
            dma_request_out <= 1'b0;
            core_clk_en <= 1'b1;
            sync_out <= 1'b0;
            sync_oe <= 1'b0;
            sh_hold <= 1'b0;
            conv_trigger <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            data_lines_out <= hi_byte ? {8'h0_0, rd_word[15:8]} : rd_word;
            data_lines_oe <= {{8{rd_act & ~byte_mode}},
                {8{rd_act}}};
            int_n <= ~|(int_stat & int_en[`ACQ_IE_MASK_HI:0]);
            dma_request_out <= (fifo_count == dma_thr);
            core_clk_en <= eff_cs_n;
            sync_prev <= p.sync_in;
            sync_oe <= sync_dir;
            // input mode: a rising sync edge holds, the next clock starts
            sh_hold <= ~sync_dir & p.sync_in & ~sync_prev;
            conv_trigger <= sh_hold;
            if (!sync_dir) begin
                sync_out <= 1'b0;
            end else if (conv_start) begin
                sync_out <= 1'b1;
            end else if (conv_done) begin
                sync_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [`ACQ_EV_W-1:0] irq_stat; // sticky events, write one to clear
    logic [`ACQ_EV_W-1:0] irq_mask; // one enables the event
    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire hit_stat = (paddr == `ACQ_APB_IRQ_STAT);
    wire hit_mask = (paddr == `ACQ_APB_IRQ_MASK);
    wire hit_status = (paddr == `ACQ_APB_STATUS);
    wire hit_ctrl = (paddr == `ACQ_APB_CTRL);
    wire mapped = hit_stat | hit_mask | hit_status | hit_ctrl;
    wire [`ACQ_EV_W-1:0] events = {sh_hold, overflow, rd_end, wr_end};
    wire [31:0] apb_mux =
        hit_stat ? {28'h000_0000, irq_stat} :
        hit_mask ? {28'h000_0000, irq_mask} :
        hit_status ? {22'h00_0000, state != ACQ_IDLE, ~eff_cs_n,
            sync_out, sync_dir, fifo_count} :
        32'h0000_0000;

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // answer one cycle after setup; unmapped addresses read zero and
    // flag an error, writes to them are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= setup ? apb_mux : 32'h0000_0000;
        end
    end

    // event set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
            flush <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((access & pwrite & hit_stat) ?
                pwdata[`ACQ_EV_W-1:0] : '0)) | events;
            if (access && pwrite && hit_mask) begin
                irq_mask <= pwdata[`ACQ_EV_W-1:0];
            end
            flush <= access & pwrite & hit_ctrl & pwdata[`ACQ_CTRL_FLUSH];
            irq <= |(irq_stat & irq_mask);
        end
    end

    initial begin
        if (FIFO_DEPTH != (1 << FIFO_AW)) begin
            $error("acq_host_bus_port: fifo depth must be 2**FIFO_AW");
        end
        if (IRAM_DEPTH != 8) $error("acq_host_bus_port: ram is 8 words");
    end
endmodule

/* File: acq_cfg.svh */
// constants for the acquisition host bus port: offsets, fields, resets
`ifndef ACQ_CFG_SVH
`define ACQ_CFG_SVH

// --------------------
// apb register byte offsets
// --------------------
`define ACQ_APB_IRQ_STAT 8'h00
`define ACQ_APB_IRQ_MASK 8'h04
`define ACQ_APB_STATUS 8'h08
`define ACQ_APB_CTRL 8'h0C

// --------------------
// apb interrupt event bit positions, event width and ctrl flush bit
// --------------------
`define ACQ_EV_HOST_WR 0
`define ACQ_EV_HOST_RD 1
`define ACQ_EV_FIFO_OVF 2
`define ACQ_EV_SYNC_IN 3
`define ACQ_EV_W 4
`define ACQ_CTRL_FLUSH 0

// --------------------
// host side word map (word index = address_lines[4:1])
// --------------------
`define ACQ_W_IRAM_TOP 1'b0
`define ACQ_W_CONFIG 4'h8
`define ACQ_W_INT_EN 4'h9
`define ACQ_W_INT_STAT 4'hA
`define ACQ_W_FIFO 4'hC

// --------------------
// host register fields and reset values
// --------------------
`define ACQ_CFG_SYNC_DIR 7
`define ACQ_IE_THR_HI 15
`define ACQ_IE_THR_LO 10
`define ACQ_IE_MASK_HI 7
`define ACQ_CONFIG_RST 16'h0000
`define ACQ_INT_EN_RST 16'h0000
`define ACQ_ZERO16 16'h0000

`endif

/* File: acq_pkg.sv */
// types shared by the acquisition host bus port files
package acq_pkg;
    // host pins as seen after the synchroniser
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic ale;
        logic bw;
        logic sync_in;
        logic [4:0] addr;
        logic [15:0] data;
    } acq_pins_t;

    // host access sequencing
    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_READ,
        ACQ_WRITE
    } acq_state_t;
endpackage

/* File: acq_sync2.sv */
// two flip-flop synchroniser for signals arriving from the host pins
`timescale 1ns/1ps
module acq_sync2 #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta; // first stage, read only by q

    // --------------------
    // resynchronise
    // --------------------
    // the first stage feeds nothing but the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

    initial begin
        if (W < 1) $error("acq_sync2: width must be positive");
    end
endmodule

/* File: acq_mem.sv */
// small memory with separate write and read addresses and registered read data
`timescale 1ns/1ps
module acq_mem #(
    parameter int W = 16,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH]; // storage array, no reset needed

    // --------------------
    // write and registered read
    // --------------------
    // read data lags the address by one cycle
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

    initial begin
        if ((1 << AW) < DEPTH) $error("acq_mem: address too narrow");
    end
endmodule

/* File: acq_port_monitor.sv */
// assertion checker for the acquisition host bus port pins
`timescale 1ns/1ps
module acq_port_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic ale,
    input wire logic bus_width_select,
    input wire logic [15:0] data_lines_oe,
    input wire logic sync_oe,
    input wire logic sync_out,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic core_clk_en,
    input wire logic sh_hold,
    input wire logic conv_trigger
);
    // --------------------
    // pin to output: three cycles
    // --------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_byte_float;
        (|data_lines_oe[15:8]) |-> !$past(bus_width_select, 3);
    endproperty
    a_byte_float: assert property (p_byte_float)
        else $error("upper byte driven");
    property p_word_drive;
        (|data_lines_oe) && !bus_width_select && !$past(bus_width_select, 3)
            |-> data_lines_oe == 16'hffff;
    endproperty
    a_word_drive: assert property (p_word_drive)
        else $error("word read narrow");
    property p_read_drive;
        (|data_lines_oe) |-> !$past(rd_n, 3) && !$past(cs_n, 3);
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("drive without read");
    property p_halt;
        !cs_n [*4] |-> !core_clk_en;
    endproperty
    a_halt: assert property (p_halt)
        else $error("clock runs while selected");
    property p_resume;
        (cs_n && ale) [*4] |-> core_clk_en;
    endproperty
    a_resume: assert property (p_resume)
        else $error("clock stays halted");
    property p_sync_start;
        sync_oe && conv_start |=> sync_out;
    endproperty
    a_sync_start: assert property (p_sync_start)
        else $error("sync not raised");
    property p_sync_done;
        sync_oe && conv_done && !conv_start |=> !sync_out;
    endproperty
    a_sync_done: assert property (p_sync_done)
        else $error("sync not lowered");
    property p_trigger;
        sh_hold |-> !sync_oe ##1 (conv_trigger && !sh_hold);
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("hold without start");
    property p_reset_input;
        $rose(presetn) |-> !sync_oe;
    endproperty
    a_reset_input: assert property (p_reset_input)
        else $error("sync not input");
    // main scenarios reached
    c_read: cover property (|data_lines_oe);
    c_hold: cover property (sh_hold);
    c_halt: cover property (!core_clk_en);
endmodule

bind acq_host_bus_port acq_port_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .cs_n(cs_n), .rd_n(rd_n), .ale(ale),
    .bus_width_select(bus_width_select), .data_lines_oe(data_lines_oe),
    .sync_oe(sync_oe), .sync_out(sync_out), .conv_start(conv_start),
    .conv_done(conv_done), .core_clk_en(core_clk_en), .sh_hold(sh_hold),
    .conv_trigger(conv_trigger)
);

/* File: acq_host_model.sv */
// host processor model driving the converter's parallel bus pins
`timescale 1ns/1ps
module acq_host_model (
    input wire logic pclk,
    input wire logic [15:0] data_lines_out,
    input wire logic [15:0] data_lines_oe,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic ale,
    output logic [4:0] address_lines,
    output logic [15:0] data_lines_in
);
    logic hwr = 1'b0; // host drives the data lines
    logic [15:0] hdata = 16'h0000; // host write data
    logic flt = 1'b0; // float pattern phase
    initial begin
        {cs_n, rd_n, wr_n, ale} = 4'hf;
        address_lines = 5'h00;
    end
    always @(posedge pclk) flt <= ~flt;
    assign data_lines_in = (data_lines_out & data_lines_oe) |
        (~data_lines_oe & (hwr ? hdata : ({16{flt}} ^ 16'ha5a5)));
    // one access; select low only around the strobe
    task acc(input logic w, input logic sel, input logic mux,
             input logic [4:0] a, input logic [15:0] d,
             output logic [15:0] q);
        address_lines <= a;
        cs_n <= !sel;
        hdata <= d;
        hwr <= w;
        repeat (3) @(posedge pclk);
        if (mux) begin
            ale <= 1'b0;
            repeat (3) @(posedge pclk);
            address_lines <= ~a;
        end
        rd_n <= w;
        wr_n <= !w;
        repeat (6) @(posedge pclk);
        q = data_lines_in;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (4) @(posedge pclk);
        cs_n <= 1'b1;
        hwr <= 1'b0;
        ale <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
endmodule

/* File: acq_tb.sv */
// self-checking bench for the acquisition host bus port
`timescale 1ns/1ps
`include "acq_cfg.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, core_events;
    logic [31:0] pwdata, prdata, aq;
    logic cs_n, rd_n, wr_n, ale, bw, sync_in, sync_out, sync_oe, int_n;
    logic dma, result_valid, conv_start, conv_done, core_clk_en;
    logic sh_hold, conv_trigger, ae;
    logic [4:0] addr;
    logic [15:0] din, dout, doe, result_data, q, r0, r1;
    logic [15:0] exp_ram [8];
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 32'h4475029c;
    int i;
    always #5 pclk = ~pclk;
    acq_host_model host_u (.pclk(pclk), .data_lines_out(dout),
        .data_lines_oe(doe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .ale(ale), .address_lines(addr), .data_lines_in(din));
    acq_host_bus_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
        .bus_width_select(bw), .address_lines(addr), .data_lines_in(din),
        .data_lines_out(dout), .data_lines_oe(doe), .sync_in(sync_in),
        .sync_out(sync_out), .sync_oe(sync_oe), .int_n(int_n),
        .dma_request_out(dma), .core_events(core_events),
        .result_valid(result_valid), .result_data(result_data),
        .conv_start(conv_start), .conv_done(conv_done),
        .core_clk_en(core_clk_en), .sh_hold(sh_hold),
        .conv_trigger(conv_trigger));
    // --------------------
    // helpers
    // --------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // held until pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        aq = prdata;
        ae = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [15:0] ie_word(logic [7:0] m, logic [5:0] t);
        return {t, 2'b00, m};
    endfunction
    task pulse_ev(input logic [7:0] ev);
        core_events <= ev;
        tick(1);
        core_events <= 8'h00;
        tick(4);
    endtask
    task end_sim;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // --------------------
    // main sequence
    // --------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {bw, sync_in, core_events, result_valid, result_data} = '0;
        {conv_start, conv_done} = '0;
        tick(20);
        presetn <= 1'b1;
        tick(3);
        chk(sync_oe, 1'b0);
        chk(int_n, 1'b1);
        for (i = 0; i < 8; i++) begin
            exp_ram[i] = 16'($random(seed));
            host_u.acc(1, 1, 0, {1'b0, i[2:0], i[0]}, exp_ram[i], q);
        end
        for (i = 0; i < 8; i++) begin
            host_u.acc(0, 1, i == 7, {1'b0, i[2:0], 1'b0}, 16'h0, q);
            chk(q, exp_ram[i]);
        end
        bw <= 1'b1;
        tick(4);
        host_u.acc(1, 1, 0, 5'h06, {8'($random(seed)), 8'h5a}, q);
        host_u.acc(1, 1, 0, 5'h07, {8'($random(seed)), 8'hc3}, q);
        host_u.acc(0, 1, 0, 5'h07, 16'h0, q);
        chk(q[7:0], 8'hc3);
        bw <= 1'b0;
        tick(4);
        host_u.acc(1, 0, 0, 5'h06, 16'h1234, q);
        host_u.acc(0, 1, 0, 5'h06, 16'h0, q);
        chk(q, 16'hc35a);
        host_u.acc(1, 1, 0, {`ACQ_W_INT_EN, 1'b0}, ie_word(8'hfb, 6'd2), q);
        pulse_ev(8'h04);
        chk(int_n, 1'b1);
        pulse_ev(8'h01);
        chk(int_n, 1'b0);
        host_u.acc(0, 1, 0, {`ACQ_W_INT_STAT, 1'b0}, 16'h0, q);
        chk(q[7:0], 8'h05);
        chk(int_n, 1'b1);
        r0 = 16'($random(seed));
        r1 = 16'($random(seed));
        result_data <= r0;
        result_valid <= 1'b1;
        tick(1);
        result_data <= r1;
        tick(1);
        result_valid <= 1'b0;
        tick(3);
        chk(dma, 1'b1);
        apb(0, `ACQ_APB_STATUS, 32'h0);
        chk(aq[5:0], 6'd2);
        host_u.acc(0, 1, 0, {`ACQ_W_FIFO, 1'b0}, 16'h0, q);
        chk(q, r0);
        chk(dma, 1'b0);
        apb(1, `ACQ_APB_IRQ_MASK, 32'h1);
        tick(2);
        chk(irq, 1'b1);
        apb(0, `ACQ_APB_IRQ_STAT, 32'h0);
        chk(aq[1:0], 2'b11);
        apb(1, `ACQ_APB_IRQ_STAT, 32'hf);
        tick(2);
        chk(irq, 1'b0);
        apb(0, 8'h40, 32'h0);
        chk({aq, ae}, 33'h1);
        host_u.acc(1, 1, 0, {`ACQ_W_CONFIG, 1'b0}, 16'h0080, q);
        tick(1);
        chk(sync_oe, 1'b1);
        conv_start <= 1'b1;
        tick(1);
        conv_start <= 1'b0;
        tick(1);
        chk(sync_out, 1'b1);
        conv_done <= 1'b1;
        tick(1);
        conv_done <= 1'b0;
        tick(1);
        chk(sync_out, 1'b0);
        host_u.acc(1, 1, 0, {`ACQ_W_CONFIG, 1'b0}, 16'h0000, q);
        sync_in <= 1'b1;
        i = 0;
        while (sh_hold !== 1'b1 && i < 10) begin
            tick(1);
            i++;
        end
        chk(sh_hold, 1'b1);
        tick(1);
        chk(conv_trigger, 1'b1);
        sync_in <= 1'b0;
        chk(core_clk_en, 1'b1);
        end_sim;
    end
    // watchdog against a hung handshake
    initial begin
        #100us;
        n_mismatch++;
        end_sim;
    end
endmodule
